// ===== rtl/mdfm_fault_mgr.sv
// Purpose: Fault supervision, bridge shutdown, fault pin and fallback PWM clock
// Assumes: Condition inputs are synchronous levels from the analog monitors
// Notes: Registers over APB; sticky status, read-clear interrupt status
// Contract
// - With PWM at 100% duty, internal clock edge re-enables tripped high side.
// - Fallback clock 20 or 40 kHz by select bit; pin variant fixed 20 kHz.
// - Supply undervoltage disables switches, charge pump, logic; bridge Hi-Z; auto resume.
// - After supply undervoltage, power-on status stays low until cleared.
// - Regulator undervoltage acts like supply undervoltage, including power-on status.
// - Buck undervoltage stops buck only, drives fault pin, sets buck flags.
// - Buck restarts and pin releases automatically; buck flags stay until cleared.
// - Memory read fault drives pin, Hi-Z bridge; latched until reset or sleep pulse.
// - Over-voltage ignored when disabled; else report, Hi-Z, auto recover.
// - Over-current: latch, retry, report only, or ignore per mode field.
// - Serial error keeps bridge active; reported unless report control set.
// - Thermal warning keeps bridge; pin only if enabled; flag kept until cleared.
// - Thermal shutdown drives pin, Hi-Z bridge, auto recovers; flag kept.
// - Current-limit trip holds high side off until next PWM period.
`timescale 1ns/1ps
module mdfm_fault_mgr #(
    parameter int unsigned SERIAL_CFG = 1,
    parameter int unsigned FB_SLOW_CYC = mdfm_pkg::FB_SLOW_CYC,
    parameter int unsigned FB_FAST_CYC = mdfm_pkg::FB_FAST_CYC,
    parameter int unsigned RETRY_CYC = mdfm_pkg::RETRY_CYC
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rstn_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Monitor conditions
    input wire logic vm_uv_i,
    input wire logic avdd_uv_i,
    input wire logic buck_undervoltage_flag_i,
    input wire logic cp_uv_i,
    input wire logic ov_i,
    input wire logic oc_i,
    input wire logic serial_err_i,
    input wire logic otp_err_i,
    input wire logic otw_i,
    input wire logic ots_i,
    // PWM path and pins
    input wire logic pwm_i,
    input wire logic current_limit_threshold_trip_i,
    input wire logic sleep_pin_n_i,
    // Responses
    output logic fault_pin_n_o,
    output logic bridge_hiz_o,
    output logic hs_enable_o,
    output logic buck_off_o,
    output logic cp_off_o,
    output logic logic_off_o,
    output logic irq_o
);
    import mdfm_pkg::*;

    initial begin
        if (SERIAL_CFG > 1) $error("mdfm_fault_mgr: SERIAL_CFG must be 0 or 1");
        if (FB_FAST_CYC < 2 || FB_SLOW_CYC >= 65536) $error("mdfm_fault_mgr: bad PWM period");
    end

    logic ov_en_reg;
    mdfm_oc_mode_t oc_mode_reg;
    logic ser_rep_reg;
    logic thermal_warning_report_en_reg;
    logic fast_sel_reg;
    logic [STAT_W-1:0] st_reg;
    logic [STAT_W-1:0] st_set;
    logic [STAT_W-1:0] st_clr;
    logic [STAT_W-1:0] irq_stat_reg;
    logic [STAT_W-1:0] irq_mask_reg;
    logic [STAT_W-1:0] ev;
    logic [STAT_W-1:0] cond;
    logic por_reg;
    logic sleep_q_reg;
    logic pwm_q_reg;
    logic pwm_low_seen_reg;
    logic hs_block_reg;
    logic hs_block_next;
    logic oc_latch_reg;
    logic oc_rep_reg;
    logic fault_reg;
    logic fault_next;
    logic hiz_next;
    logic retry_busy;
    logic fb_tick;
    logic [15:0] fb_period;
    logic acc, wr, rd, mapped, clr_any, sleep_pulse, power_down, ov_act;
    logic [31:0] rdata;

    // APB access phase: answered the cycle after penable rises
    assign acc = psel_i && penable_i && !pready_o;
    assign wr = acc && pwrite_i;
    assign rd = acc && !pwrite_i;
    assign sleep_pulse = sleep_pin_n_i && !sleep_q_reg;
    assign clr_any = (wr && paddr_i == CTRL_OFF && pwdata_i[CTRL_CLR_BIT]) || sleep_pulse;
    assign power_down = vm_uv_i || avdd_uv_i;
    assign ov_act = ov_i && ov_en_reg;

    always_comb begin
        mapped = 1'b1;
        rdata = '0;
        case (paddr_i)
            CTRL_OFF: begin
                rdata[CTRL_OVEN_BIT] = ov_en_reg;
                rdata[CTRL_OCM_LSB +: 2] = oc_mode_reg;
                rdata[CTRL_SERREP_BIT] = ser_rep_reg;
                rdata[CTRL_OTWREP_BIT] = thermal_warning_report_en_reg;
                rdata[CTRL_FAST_BIT] = fast_sel_reg;
            end
            STAT_OFF: rdata[STAT_W-1:0] = st_reg;
            IRQ_STAT_OFF: rdata[STAT_W-1:0] = irq_stat_reg;
            IRQ_MASK_OFF: rdata[STAT_W-1:0] = irq_mask_reg;
            COND_OFF: rdata[STAT_W-1:0] = cond;
            default: mapped = 1'b0;
        endcase
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= '0;
        end else begin
            pready_o <= acc;
            pslverr_o <= acc && !mapped;
            prdata_o <= rd ? rdata : 32'h0000_0000;
        end
    end

    // Control register; the clear bit is a self-clearing strobe
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ov_en_reg <= CTRL_RST[CTRL_OVEN_BIT];
            oc_mode_reg <= mdfm_oc_mode_t'(CTRL_RST[CTRL_OCM_LSB +: 2]);
            ser_rep_reg <= CTRL_RST[CTRL_SERREP_BIT];
            thermal_warning_report_en_reg <= CTRL_RST[CTRL_OTWREP_BIT];
            fast_sel_reg <= CTRL_RST[CTRL_FAST_BIT];
            irq_mask_reg <= MASK_RST;
        end else if (wr && paddr_i == CTRL_OFF) begin
            ov_en_reg <= pwdata_i[CTRL_OVEN_BIT];
            oc_mode_reg <= mdfm_oc_mode_t'(pwdata_i[CTRL_OCM_LSB +: 2]);
            ser_rep_reg <= pwdata_i[CTRL_SERREP_BIT];
            thermal_warning_report_en_reg <= pwdata_i[CTRL_OTWREP_BIT];
            fast_sel_reg <= pwdata_i[CTRL_FAST_BIT] && (SERIAL_CFG != 0);
        end else if (wr && paddr_i == IRQ_MASK_OFF) begin
            irq_mask_reg <= pwdata_i[STAT_W-1:0];
        end
    end

    // Sticky flags: set wins over clear
    always_comb begin
        st_set = '0;
        st_set[ST_BUCK_FLT] = buck_undervoltage_flag_i;
        st_set[ST_BUCK_UNDERVOLTAGE_FLAG] = buck_undervoltage_flag_i;
        st_set[ST_CP_UV] = cp_uv_i;
        st_set[ST_OV] = ov_act;
        st_set[ST_OC] = oc_i && oc_mode_reg != MDFM_OC_OFF;
        st_set[ST_SER] = serial_err_i;
        st_set[ST_OTP] = otp_err_i;
        st_set[ST_OTW] = otw_i;
        st_set[ST_OTS] = ots_i;
        st_set[ST_FAULT] = fault_next;
        st_clr = {STAT_W{clr_any}};
        st_clr[ST_OTP] = sleep_pulse;
        st_clr[ST_FAULT] = 1'b1;
        st_clr[ST_POR] = 1'b1;
    end

    genvar gi;
    generate
        for (gi = 0; gi < STAT_W; gi++) begin : g_sticky
            if (gi == ST_POR) begin : g_por
                always_ff @(posedge clock_i or negedge rstn_i) begin
                    if (!rstn_i) st_reg[gi] <= 1'b0;
                    else st_reg[gi] <= por_reg;
                end
            end else begin : g_flag
                always_ff @(posedge clock_i or negedge rstn_i) begin
                    if (!rstn_i) st_reg[gi] <= 1'b0;
                    else st_reg[gi] <= st_set[gi] || (st_reg[gi] && !st_clr[gi]);
                end
            end
        end
    endgenerate

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) por_reg <= 1'b0;
        else if (power_down) por_reg <= 1'b0;
        else if (clr_any) por_reg <= 1'b1;
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            oc_latch_reg <= 1'b0;
            oc_rep_reg <= 1'b0;
        end else begin
            if (oc_i && oc_mode_reg == MDFM_OC_LATCH) oc_latch_reg <= 1'b1;
            else if (clr_any) oc_latch_reg <= 1'b0;
            if (oc_i && oc_mode_reg == MDFM_OC_REPORT) oc_rep_reg <= 1'b1;
            else if (clr_any) oc_rep_reg <= 1'b0;
        end
    end

    mdfm_retry_timer #(
        .W(CNT_W),
        .COUNT(RETRY_CYC)
    ) u_retry (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .start_i(oc_i && oc_mode_reg == MDFM_OC_RETRY),
        .busy_o(retry_busy)
    );

    assign fb_period = fast_sel_reg ? 16'(FB_FAST_CYC) : 16'(FB_SLOW_CYC);

    mdfm_tick_gen #(
        .W(16)
    ) u_fb_clk (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .period_i(fb_period),
        .tick_o(fb_tick)
    );

    assign hiz_next = power_down || cp_uv_i || ov_act || oc_latch_reg || retry_busy
        || st_reg[ST_OTP] || otp_err_i || ots_i;

    // fault pin OR of reported faults
    assign fault_next = !power_down && (buck_undervoltage_flag_i || cp_uv_i || ov_act || oc_latch_reg
        || retry_busy || oc_rep_reg || (st_reg[ST_SER] && !ser_rep_reg)
        || (otw_i && thermal_warning_report_en_reg) || ots_i || st_reg[ST_OTP] || otp_err_i);

    always_comb begin
        hs_block_next = hs_block_reg;
        if (current_limit_threshold_trip_i) hs_block_next = 1'b1;
        // Tick only frees after a whole tick period of unbroken high input
        else if (pwm_i && (!pwm_q_reg || (fb_tick && !pwm_low_seen_reg)))
            hs_block_next = 1'b0;
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pwm_q_reg <= 1'b0;
            sleep_q_reg <= 1'b1;
            hs_block_reg <= 1'b0;
            hs_enable_o <= 1'b0;
            pwm_low_seen_reg <= 1'b1;
        end else begin
            pwm_q_reg <= pwm_i;
            // window restarts at each tick; any low sample marks it
            if (fb_tick) pwm_low_seen_reg <= !pwm_i;
            else if (!pwm_i) pwm_low_seen_reg <= 1'b1;
            sleep_q_reg <= sleep_pin_n_i;
            hs_block_reg <= hs_block_next;
            hs_enable_o <= pwm_i && !hs_block_next && !hiz_next;
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fault_reg <= 1'b0;
            fault_pin_n_o <= 1'b1;
            bridge_hiz_o <= 1'b1;
            buck_off_o <= 1'b0;
            cp_off_o <= 1'b0;
            logic_off_o <= 1'b0;
        end else begin
            fault_reg <= fault_next;
            fault_pin_n_o <= !fault_next;
            bridge_hiz_o <= hiz_next;
            buck_off_o <= buck_undervoltage_flag_i;
            cp_off_o <= power_down;
            logic_off_o <= power_down;
        end
    end

    assign cond = {ots_i, otw_i, otp_err_i, serial_err_i, oc_i, ov_i, cp_uv_i,
        buck_undervoltage_flag_i, buck_undervoltage_flag_i, power_down, fault_reg};

    // Interrupt: new flag events; set wins over read clear
    assign ev = (st_set & ~st_reg) | {{(STAT_W-2){1'b0}}, power_down && por_reg, 1'b0};

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            irq_stat_reg <= '0;
            irq_o <= 1'b0;
        end else begin
            if (rd && paddr_i == IRQ_STAT_OFF) irq_stat_reg <= ev;
            else irq_stat_reg <= irq_stat_reg | ev;
            irq_o <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);

    logic [15:0] gap_reg;
    logic gap_ok_reg;
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            gap_reg <= '0;
            gap_ok_reg <= 1'b0;
        end else if (fb_tick) begin
            gap_reg <= '0;
            gap_ok_reg <= 1'b1;
        end else begin
            gap_reg <= gap_reg + 16'd1;
            if ($changed(fb_period)) gap_ok_reg <= 1'b0;
        end
    end

    fb_restart_a: assert property (pwm_i && pwm_q_reg && hs_block_reg && fb_tick
        && !pwm_low_seen_reg && !current_limit_threshold_trip_i |=> hs_enable_o || bridge_hiz_o)
        else $error("high side not restarted by fallback clock");
    fb_period_a: assert property (fb_tick && gap_ok_reg && $stable(fb_period)
        |-> gap_reg + 16'd1 == fb_period)
        else $error("fallback clock period wrong");
    vm_uv_off_a: assert property (vm_uv_i |=> bridge_hiz_o && cp_off_o && logic_off_o)
        else $error("supply undervoltage not shut down");
    por_hold_a: assert property (!por_reg && !clr_any |=> !por_reg)
        else $error("power-on status released without clear");
    avdd_uv_a: assert property (avdd_uv_i |=> bridge_hiz_o && logic_off_o && !por_reg)
        else $error("regulator undervoltage response wrong");
    buck_undervoltage_flag_a: assert property (buck_undervoltage_flag_i && !power_down |=> buck_off_o && !fault_pin_n_o
        && st_reg[ST_BUCK_UNDERVOLTAGE_FLAG] && st_reg[ST_BUCK_FLT])
        else $error("buck undervoltage response wrong");
    buck_keep_a: assert property (st_reg[ST_BUCK_UNDERVOLTAGE_FLAG] && !clr_any |=> st_reg[ST_BUCK_UNDERVOLTAGE_FLAG]
        && buck_off_o == $past(buck_undervoltage_flag_i))
        else $error("buck flag lost or buck not restarted");
    otp_latch_a: assert property (otp_err_i ##1 !sleep_pulse [*3] |=> bridge_hiz_o)
        else $error("memory fault not latched");
    ov_off_a: assert property (ov_i && !ov_en_reg && !st_reg[ST_OV] |=> !st_reg[ST_OV])
        else $error("over-voltage acted while disabled");
    oc_latch_a: assert property (oc_i && oc_mode_reg == MDFM_OC_LATCH && !clr_any
        ##1 !clr_any |=> bridge_hiz_o)
        else $error("over-current latch not applied");
    oc_report_a: assert property (oc_i && oc_mode_reg == MDFM_OC_REPORT && !power_down
        |=> ##1 (!fault_pin_n_o || $past(power_down)))
        else $error("over-current report missing");
    ser_rep_a: assert property (st_reg[ST_SER] && !ser_rep_reg && !power_down
        |=> !fault_pin_n_o)
        else $error("serial error not reported");
    thermal_warning_report_en_a: assert property (otw_i && !thermal_warning_report_en_reg && !st_reg[ST_OTW]
        |=> st_reg[ST_OTW])
        else $error("thermal warning flag not set");
    ots_hiz_a: assert property (ots_i && !power_down |=> bridge_hiz_o && !fault_pin_n_o)
        else $error("thermal shutdown response wrong");
    ilim_hold_a: assert property (current_limit_threshold_trip_i |=> !hs_enable_o)
        else $error("high side on after current-limit trip");
    ilim_period_a: assert property (hs_block_reg && pwm_i && pwm_q_reg && pwm_low_seen_reg
        |=> !hs_enable_o)
        else $error("high side released inside a PWM period");
    pin_quiet_a: assert property (power_down |=> fault_pin_n_o)
        else $error("fault pin driven while powered down");

    oc_retry_c: cover property (oc_i && oc_mode_reg == MDFM_OC_RETRY ##1 retry_busy);
    fb_restart_c: cover property (hs_block_reg && pwm_q_reg && fb_tick);
    irq_fire_c: cover property ($rose(irq_o));
endmodule : mdfm_fault_mgr

// ===== rtl/mdfm_pkg.sv
// Purpose: Shared constants for the motor driver fault manager
// Assumes: 100 MHz system clock, APB register access with 32-bit data
// Notes: Offsets are byte addresses of aligned words
package mdfm_pkg;
    // Clock and fallback PWM clock
    localparam int unsigned CLK_KHZ = 100000;
    localparam int unsigned FB_SLOW_KHZ = 20;
    localparam int unsigned FB_FAST_KHZ = 40;
    localparam int unsigned FB_SLOW_CYC = CLK_KHZ / FB_SLOW_KHZ;
    localparam int unsigned FB_FAST_CYC = CLK_KHZ / FB_FAST_KHZ;
    // Over-current retry interval
    localparam int unsigned RETRY_US = 5000;
    localparam int unsigned RETRY_CYC = RETRY_US * (CLK_KHZ / 1000);
    localparam int unsigned CNT_W = 20;

    // Register offsets
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] STAT_OFF = 8'h04;
    localparam logic [7:0] IRQ_STAT_OFF = 8'h08;
    localparam logic [7:0] IRQ_MASK_OFF = 8'h0c;
    localparam logic [7:0] COND_OFF = 8'h10;

    // Control fields
    localparam int unsigned CTRL_CLR_BIT = 0;
    localparam int unsigned CTRL_OVEN_BIT = 1;
    localparam int unsigned CTRL_OCM_LSB = 2;
    localparam int unsigned CTRL_SERREP_BIT = 4;
    localparam int unsigned CTRL_OTWREP_BIT = 5;
    localparam int unsigned CTRL_FAST_BIT = 6;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;

    // Status layout, shared by interrupt status and mask
    localparam int unsigned STAT_W = 11;
    localparam int unsigned ST_FAULT = 0;
    localparam int unsigned ST_POR = 1;
    localparam int unsigned ST_BUCK_FLT = 2;
    localparam int unsigned ST_BUCK_UNDERVOLTAGE_FLAG = 3;
    localparam int unsigned ST_CP_UV = 4;
    localparam int unsigned ST_OV = 5;
    localparam int unsigned ST_OC = 6;
    localparam int unsigned ST_SER = 7;
    localparam int unsigned ST_OTP = 8;
    localparam int unsigned ST_OTW = 9;
    localparam int unsigned ST_OTS = 10;
    localparam logic [STAT_W-1:0] MASK_RST = 11'h000;

    // Over-current response modes
    typedef enum logic [1:0] {
        MDFM_OC_LATCH = 2'b00,
        MDFM_OC_RETRY = 2'b01,
        MDFM_OC_REPORT = 2'b10,
        MDFM_OC_OFF = 2'b11
    } mdfm_oc_mode_t;
endpackage : mdfm_pkg

// ===== rtl/mdfm_tick_gen.sv
// Purpose: Free-running period counter giving one-cycle ticks
// Assumes: Period of at least two cycles
// Notes: A period change applies to the count in progress; a period at or below the count wraps at the next edge
`timescale 1ns/1ps
module mdfm_tick_gen #(
    parameter int unsigned W = 16
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rstn_i,
    // Period in cycles
    input wire logic [W-1:0] period_i,
    // Tick
    output logic tick_o
);
    logic [W-1:0] cnt_reg;

    initial begin
        if (W < 2) $error("mdfm_tick_gen: W too small");
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_reg <= '0;
            tick_o <= 1'b0;
        end else if (cnt_reg >= period_i - W'(1)) begin
            cnt_reg <= '0;
            tick_o <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + W'(1);
            tick_o <= 1'b0;
        end
    end
endmodule : mdfm_tick_gen

// ===== rtl/mdfm_retry_timer.sv
// Purpose: One-shot interval timer for automatic retry
// Assumes: Start is ignored while the timer runs
// Notes: Busy rises the edge after start and stays for COUNT cycles
`timescale 1ns/1ps
module mdfm_retry_timer #(
    parameter int unsigned W = 20,
    parameter int unsigned COUNT = 500000
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rstn_i,
    // Control
    input wire logic start_i,
    // Status
    output logic busy_o
);
    logic [W-1:0] left_reg;

    initial begin
        if (COUNT < 1 || COUNT >= (64'd1 << W)) $error("mdfm_retry_timer: bad COUNT");
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            left_reg <= '0;
            busy_o <= 1'b0;
        end else if (!busy_o && start_i) begin
            left_reg <= W'(COUNT - 1);
            busy_o <= 1'b1;
        end else if (busy_o) begin
            left_reg <= left_reg - W'(1);
            busy_o <= (left_reg != '0);
        end
    end
endmodule : mdfm_retry_timer

// ===== testbench/mdfm_pwm_model.sv
// Purpose: Controller-side PWM source feeding the driver
// Assumes: Period in clock cycles, below 256
// Notes: Full duty holds the line high, so no edge ever comes
`timescale 1ns/1ps
module mdfm_pwm_model #(
    parameter int unsigned PER = 40
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rstn_i,
    // Control
    input wire logic full_i,
    // PWM line
    output logic pwm_o
);
    logic [7:0] cnt_reg;
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_reg <= 8'h00;
        end else begin
            cnt_reg <= (cnt_reg == 8'(PER - 1)) ? 8'h00 : cnt_reg + 8'h01;
        end
    end
    assign pwm_o = full_i | (cnt_reg < 8'(PER / 2));
endmodule : mdfm_pwm_model

// ===== testbench/motor_driver_fault_manager_tb.sv
// Purpose: Self-checking bench for the fault manager
// Assumes: Shortened fallback and retry counts
// Notes: Reads are checked by a monitor against queued notes
`timescale 1ns/1ps
module motor_driver_fault_manager_tb;
    import mdfm_pkg::*;
    localparam int RTY = 20;
    logic clock_i = 0, rstn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0, prdata_o, ctrl;
    logic pready_o, pslverr_o, fault_pin_n_o, bridge_hiz_o, hs_enable_o, irq_o;
    logic buck_off_o, cp_off_o, logic_off_o, pwm, full = 0, trip = 0, sleep_pin_n_i = 1;
    logic [10:0] cnd = '0;
    logic [32:0] eq[$], mq[$], m_n, e_n;
    int num_errors = 0, n_tests = 0, cyc = 0, k;
    int unsigned tb_b[8] = '{ST_BUCK_UNDERVOLTAGE_FLAG, ST_OTS, ST_OTW, ST_OTW, ST_SER, ST_SER, ST_OV, ST_OV};
    logic [6:0] tb_c[8] = '{7'h00, 7'h00, 7'h00, 7'h20, 7'h00, 7'h10, 7'h00, 7'h02};
    // Expected hiz, pin during, pin after drop, sticky flag
    logic [3:0] tb_x[8] = '{4'h3, 4'hb, 4'h7, 4'h3, 4'h1, 4'h7, 4'h6, 4'hb};

    mdfm_fault_mgr #(.FB_SLOW_CYC(20), .FB_FAST_CYC(10), .RETRY_CYC(RTY)) i_mdfm_fault_mgr (
        .clock_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
        .prdata_o, .pready_o, .pslverr_o,
        .vm_uv_i(cnd[0]), .avdd_uv_i(cnd[1]), .buck_undervoltage_flag_i(cnd[ST_BUCK_UNDERVOLTAGE_FLAG]),
        .cp_uv_i(cnd[ST_CP_UV]), .ov_i(cnd[ST_OV]), .oc_i(cnd[ST_OC]),
        .serial_err_i(cnd[ST_SER]), .otp_err_i(cnd[ST_OTP]), .otw_i(cnd[ST_OTW]),
        .ots_i(cnd[ST_OTS]), .pwm_i(pwm), .current_limit_threshold_trip_i(trip), .sleep_pin_n_i,
        .fault_pin_n_o, .bridge_hiz_o, .hs_enable_o, .buck_off_o, .cp_off_o,
        .logic_off_o, .irq_o
    );
    mdfm_pwm_model #(.PER(40)) i_mdfm_pwm_model (
        .clock_i, .rstn_i, .full_i(full), .pwm_o(pwm)
    );

    initial forever #5 clock_i = ~clock_i;

    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up

    // Hang guard, well above the whole sequence
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            wrap_up();
        end
    end

    // Read monitor: oldest note against each completed read
    always @(posedge clock_i) begin
        if (pready_o && psel_i && penable_i && !pwrite_i && eq.size() > 0) begin
            m_n = mq.pop_front();
            e_n = eq.pop_front();
            n_tests++;
            if (({pslverr_o, prdata_o} & m_n) !== e_n) begin
                num_errors++;
                $display("BAD read %h exp %h got %h", paddr_i, e_n, {pslverr_o, prdata_o} & m_n);
            end
        end
    end

    function automatic logic [32:0] bm(input int b);
        return 33'(1) << b;
    endfunction : bm

    task automatic w(input int n);
        repeat (n) @(posedge clock_i);
    endtask : w

    task automatic chk(input string nm, input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s exp %b got %b", nm, exp, got);
        end
    endtask : chk

    // Held until pready is seen at an edge
    task automatic apb(input logic [7:0] a, input logic wr, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clock_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clock_i);
            n++;
        end while (pready_o !== 1'b1 && n < 50);
        if (pready_o !== 1'b1) begin
            num_errors++;
            $display("BAD pready exp 1 got %b", pready_o);
        end
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [32:0] m, input logic [32:0] e);
        mq.push_back(m);
        eq.push_back(e);
        apb(a, 1'b0, 32'h0);
    endtask : rd

    task automatic clr();
        apb(CTRL_OFF, 1'b1, ctrl | 32'h1);
        w(2);
    endtask : clr

    task automatic fault(input int b, input logic hz, input logic pn);
        cnd[b] <= 1'b1;
        w(3);
        chk("hiz", bridge_hiz_o, hz);
        chk("pin", fault_pin_n_o, pn);
        cnd[b] <= 1'b0;
        w(3);
    endtask : fault

    initial begin
        void'($urandom(96));
        ctrl = 32'h0;
        w(5);
        rstn_i <= 1'b1;
        rd(STAT_OFF, bm(ST_POR), 33'h0);
        rd(CTRL_OFF, 33'h0_ffff_ffff, 33'h0);
        rd(IRQ_MASK_OFF, 33'h0_ffff_ffff, 33'h0);
        rd(8'h20, 33'h1_ffff_ffff, 33'h1_0000_0000);
        clr();
        rd(STAT_OFF, bm(ST_POR), bm(ST_POR));
        for (int s = 0; s < 2; s++) begin
            cnd[s] <= 1'b1;
            w(3);
            chk("hiz", bridge_hiz_o, 1'b1);
            chk("cp_off", cp_off_o, 1'b1);
            chk("logic_off", logic_off_o, 1'b1);
            chk("pin", fault_pin_n_o, 1'b1);
            cnd[s] <= 1'b0;
            w(3);
            chk("hiz", bridge_hiz_o, 1'b0);
            rd(STAT_OFF, bm(ST_POR), 33'h0);
            clr();
            rd(STAT_OFF, bm(ST_POR), bm(ST_POR));
        end
        $display("Supply tests done");
        for (int i = 0; i < 8; i++) begin
            ctrl = {25'h0, tb_c[i]};
            apb(CTRL_OFF, 1'b1, ctrl | ($urandom & 32'hffff_ff80));
            cnd[tb_b[i]] <= 1'b1;
            w(3);
            chk("buck_off", buck_off_o, 1'(tb_b[i] == ST_BUCK_UNDERVOLTAGE_FLAG));
            fault(tb_b[i], tb_x[i][3], tb_x[i][2]);
            chk("hiz", bridge_hiz_o, 1'b0);
            chk("pin", fault_pin_n_o, tb_x[i][1]);
            rd(STAT_OFF, bm(tb_b[i]), tb_x[i][0] ? bm(tb_b[i]) : 33'h0);
            clr();
            rd(STAT_OFF, bm(tb_b[i]), 33'h0);
            chk("pin", fault_pin_n_o, 1'b1);
        end
        $display("Condition tests done");
        for (int md = 0; md < 4; md++) begin
            ctrl = 32'(md) << CTRL_OCM_LSB;
            apb(CTRL_OFF, 1'b1, ctrl);
            fault(ST_OC, 1'(md < 2), 1'(md == 3));
            chk("hiz", bridge_hiz_o, 1'(md < 2));
            w(RTY + 5);
            chk("hiz", bridge_hiz_o, 1'(md == 0));
            chk("pin", fault_pin_n_o, 1'(md % 2));
            clr();
            chk("hiz", bridge_hiz_o, 1'b0);
        end
        $display("Over-current tests done");
        apb(IRQ_MASK_OFF, 1'b1, 32'(bm(ST_OTS)));
        rd(IRQ_STAT_OFF, bm(ST_OTS), bm(ST_OTS));
        cnd[ST_OTS] <= 1'b1;
        w(4);
        chk("irq", irq_o, 1'b1);
        rd(COND_OFF, bm(ST_OTS), bm(ST_OTS));
        cnd[ST_OTS] <= 1'b0;
        rd(IRQ_STAT_OFF, bm(ST_OTS), bm(ST_OTS));
        w(3);
        chk("irq", irq_o, 1'b0);
        apb(IRQ_MASK_OFF, 1'b1, 32'h0);
        fault(ST_OTS, 1'b1, 1'b0);
        chk("irq", irq_o, 1'b0);
        clr();
        fault(ST_OTP, 1'b1, 1'b0);
        clr();
        chk("hiz", bridge_hiz_o, 1'b1);
        sleep_pin_n_i <= 1'b0;
        w(2);
        sleep_pin_n_i <= 1'b1;
        w(3);
        chk("hiz", bridge_hiz_o, 1'b0);
        chk("pin", fault_pin_n_o, 1'b1);
        $display("Interrupt and memory tests done");
        // Trip early in a high phase; only the next rising edge may free it
        while (pwm !== 1'b0) w(1);
        while (pwm !== 1'b1) w(1);
        trip <= 1'b1;
        w(1);
        trip <= 1'b0;
        w(12);
        chk("hs", hs_enable_o, 1'b0);
        while (pwm !== 1'b0) w(1);
        while (pwm !== 1'b1) w(1);
        w(3);
        chk("hs", hs_enable_o, 1'b1);
        full <= 1'b1;
        // One tick must see the held-high input before the first trip
        w(20);
        for (int f = 0; f < 2; f++) begin
            ctrl = 32'(f) << CTRL_FAST_BIT;
            apb(CTRL_OFF, 1'b1, ctrl);
            trip <= 1'b1;
            w(1);
            trip <= 1'b0;
            k = 0;
            do begin
                w(1);
                k++;
            end while (hs_enable_o !== 1'b1 && k < 60);
            chk("fallback", 1'(k >= 2 && k <= (f ? 14 : 24)), 1'b1);
        end
        $display("Current limit tests done");
        wrap_up();
    end
endmodule : motor_driver_fault_manager_tb
